// ---- verilog/pcss_top.sv ----
// pci clock speed select: drives the clock generator 33/66 MHz select
`timescale 1ns/10ps
module pcss_top
    import pcss_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // board pins
    input  wire logic        pci_m66_capable_in,
    input  wire logic        speed_limit_jumper_in,
    output logic             clock_speed_select_out
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic pcss_hit(input logic [31:0] addr, input logic [31:0] base);
        pcss_hit = (addr == base);
    endfunction : pcss_hit

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    pcss_inputs_t    raw_in;
    pcss_inputs_t    sync_in;
    pcss_bus_state_t bus_state_reg;
    pcss_req_t       req_reg;
    logic            fast_clock_enable_reg;
    logic            sel_next;
    logic            accept;
    logic            en_write;
    logic            fast_clock_enable_next;

    assign raw_in = '{cap: pci_m66_capable_in, jumper: speed_limit_jumper_in};

    pcss_sync #(
        .WIDTH    (2)
    ) u_sync (
        .clk_in   (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    // ------------------------------------------------------------------
    // select logic
    // ------------------------------------------------------------------
    // any single control pulls the clocks down to 33 MHz
    assign sel_next = sync_in.cap & fast_clock_enable_reg & ~sync_in.jumper;

    // registered so the generator pin never glitches; recomputed every
    // cycle so a slow card drops the rate without software help
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            clock_speed_select_out <= 1'b0;
        end else begin
            clock_speed_select_out <= sel_next;
        end
    end

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    assign accept = hsel_in & hready_in & htrans_in[1];

    // a read right behind a write shares the edge on which the write lands,
    // so it must see the bit being written rather than the stale one
    assign en_write = (bus_state_reg == PCSS_BUS_DATA) & req_reg.write & req_reg.word
                      & (req_reg.index == 4'h1);
    assign fast_clock_enable_next = en_write ? hwdata_in[PCSS_EN_BIT] : fast_clock_enable_reg;

    // address phase capture; zero wait state data phase
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bus_state_reg <= PCSS_BUS_IDLE;
            req_reg       <= '0;
        end else begin
            bus_state_reg <= accept ? PCSS_BUS_DATA : PCSS_BUS_IDLE;
            if (accept) begin
                req_reg.write <= hwrite_in;
                req_reg.word  <= (hsize_in == PCSS_HSIZE_WORD);
                req_reg.index <= pcss_hit(haddr_in, PCSS_CLK_CFG_ADDR) ? 4'h1 :
                                 pcss_hit(haddr_in, PCSS_STATUS_ADDR)  ? 4'h2 : 4'h0;
            end
        end
    end

    // enable bit; narrow writes are ignored since only words are legal
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fast_clock_enable_reg <= PCSS_EN_RESET;
        end else begin
            case (bus_state_reg)
                PCSS_BUS_DATA: begin
                    if (req_reg.write && req_reg.word && req_reg.index == 4'h1) begin
                        fast_clock_enable_reg <= hwdata_in[PCSS_EN_BIT];
                    end
                end
                default: begin
                    fast_clock_enable_reg <= fast_clock_enable_reg;
                end
            endcase
        end
    end

    // read data registered at the address phase; unmapped reads zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            hrdata_out    <= PCSS_ZERO_WORD;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= PCSS_ZERO_WORD;
            if (accept && !hwrite_in) begin
                if (pcss_hit(haddr_in, PCSS_CLK_CFG_ADDR)) begin
                    hrdata_out[PCSS_EN_BIT] <= fast_clock_enable_next;
                end else if (pcss_hit(haddr_in, PCSS_STATUS_ADDR)) begin
                    hrdata_out[PCSS_ST_SEL_BIT] <= clock_speed_select_out;
                    hrdata_out[PCSS_ST_CAP_BIT] <= sync_in.cap;
                    hrdata_out[PCSS_ST_JMP_BIT] <= sync_in.jumper;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    slow_card_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !sync_in.cap |=> !clock_speed_select_out)
        else $error("select high while a slow card is present");

    enable_reset_a: assert property (@(posedge clk_in)
        sys_rst_in |=> !fast_clock_enable_reg)
        else $error("enable bit not cleared by reset");

    disabled_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !fast_clock_enable_reg |=> !clock_speed_select_out)
        else $error("select high while enable bit clear");

    jumper_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sync_in.jumper |=> !clock_speed_select_out)
        else $error("select high with jumper fitted");

    all_high_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (sync_in.cap && fast_clock_enable_reg && !sync_in.jumper)
        |=> clock_speed_select_out)
        else $error("select low although all conditions allow 66 MHz");

    auto_follow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(pci_m66_capable_in) ##1 !pci_m66_capable_in
        |-> ##[1:2] !clock_speed_select_out)
        else $error("select did not drop after slot capability fell");

    write_en_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (hsel_in && hready_in && htrans_in == PCSS_HTRANS_NONSEQ && hwrite_in
         && hsize_in == PCSS_HSIZE_WORD && haddr_in == PCSS_CLK_CFG_ADDR)
        ##1 1'b1 |=> fast_clock_enable_reg == $past(hwdata_in[0]))
        else $error("enable bit write not stored");

    narrow_ign_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (accept && hwrite_in && hsize_in != PCSS_HSIZE_WORD) ##1 1'b1
        |=> $stable(fast_clock_enable_reg))
        else $error("narrow write changed the enable bit");

    sync_delay_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(speed_limit_jumper_in) ##1 speed_limit_jumper_in
        |-> ##1 sync_in.jumper)
        else $error("jumper not synchronised in two cycles");

    cap_sync_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(pci_m66_capable_in) ##1 pci_m66_capable_in
        |-> ##1 sync_in.cap)
        else $error("capability not synchronised in two cycles");

    sel_steady_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ($stable(sync_in) && $stable(fast_clock_enable_reg))
        |=> $stable(clock_speed_select_out))
        else $error("select moved although its inputs held still");

    unmapped_ign_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (accept && hwrite_in && haddr_in != PCSS_CLK_CFG_ADDR) ##1 1'b1
        |=> $stable(fast_clock_enable_reg))
        else $error("write to another address changed the enable bit");

    cfg_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (accept && !hwrite_in && haddr_in == PCSS_CLK_CFG_ADDR && !en_write)
        |=> hrdata_out == {31'h0, $past(fast_clock_enable_reg)})
        else $error("config read does not return the enable bit");

    status_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (accept && !hwrite_in && haddr_in == PCSS_STATUS_ADDR)
        |=> hrdata_out[PCSS_ST_SEL_BIT] == $past(clock_speed_select_out))
        else $error("status read does not show the live select");

    rdata_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(accept && !hwrite_in)
        |=> hrdata_out == PCSS_ZERO_WORD)
        else $error("read data not zero outside a read data phase");

    bus_okay_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        hreadyout_out && !hresp_out)
        else $error("bus slave stalled or answered with an error");

endmodule : pcss_top

// ---- verilog/pcss_pkg.sv ----
// package for the pci clock speed select block
package pcss_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [31:0] PCSS_CLK_CFG_ADDR  = 32'h0000_0000; // enable bit lives here
    localparam logic [31:0] PCSS_STATUS_ADDR   = 32'h0000_0004; // live state, read only
    localparam int          PCSS_EN_BIT        = 0;
    localparam int          PCSS_ST_SEL_BIT    = 0;
    localparam int          PCSS_ST_CAP_BIT    = 1;
    localparam int          PCSS_ST_JMP_BIT    = 2;
    localparam logic        PCSS_EN_RESET      = 1'b0;
    localparam logic [31:0] PCSS_ZERO_WORD     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // ahb-lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  PCSS_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  PCSS_HSIZE_WORD    = 3'h2;

    // ------------------------------------------------------------------
    // bus state and synchronised inputs
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        PCSS_BUS_IDLE = 1'b0,
        PCSS_BUS_DATA = 1'b1
    } pcss_bus_state_t;

    typedef struct packed {
        logic       write;
        logic       word;
        logic [3:0] index;
    } pcss_req_t;

    typedef struct packed {
        logic cap;     // all slots 66 MHz capable
        logic jumper;  // speed limit shunt fitted
    } pcss_inputs_t;

endpackage : pcss_pkg

// ---- verilog/pcss_sync.sv ----
// two-flop synchroniser for the slot and jumper levels
`timescale 1ns/10ps
module pcss_sync
    import pcss_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // first stage is read only by the second
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule : pcss_sync

// ---- verification/pcss_clkgen_model.sv ----
// clock generator model: speed select in, one reference clock and its rate out
`timescale 1ns/10ps
module pcss_clkgen_model (
    // select from the block
    input  wire logic       speed_sel_in,
    // generated clock and its rate in mhz
    output logic            ref_clk_out,
    output logic [7:0]      mhz_out
);
    // rate follows the select level: 66 high, 33 low
    assign mhz_out = speed_sel_in ? 8'h42 : 8'h21;
    // free running reference, half period chosen by the select
    initial ref_clk_out = 1'b0;
    always #(speed_sel_in ? 7.5 : 15.0) ref_clk_out = ~ref_clk_out;
endmodule : pcss_clkgen_model

// ---- verification/test_pci_clock_speed_select.sv ----
// self-checking bench for the pci clock speed select block
`timescale 1ns/10ps
module test_pci_clock_speed_select;
    import pcss_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        cap = 1'b1;
    logic        jmp = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hready;
    logic        hresp;
    logic        sel;
    logic [7:0]  mhz;
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // rows: {capable, jumper, enable, expected select}
    logic [3:0]  rows [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hb, 4'hc, 4'he};

    always #2.5 clk_in = ~clk_in;

    pcss_top pcss_top_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .pci_m66_capable_in(cap), .speed_limit_jumper_in(jmp),
        .clock_speed_select_out(sel));
    pcss_clkgen_model pcss_clkgen_model_inst (
        .speed_sel_in(sel), .ref_clk_out(), .mhz_out(mhz));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one whole-word transfer launched on a fresh edge; holds each phase
    // until hready is seen high
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rdo);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= PCSS_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= PCSS_HSIZE_WORD;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rdo = hrdata;
    endtask : xfer

    // change the pins, then see the select hold two edges and move on the third
    task automatic pin_step(input logic c, input logic j, input logic b, input logic f);
        @(posedge clk_in);
        cap <= c;
        jmp <= j;
        repeat (2) @(posedge clk_in);
        #1 chk({31'h0, sel}, {31'h0, b});
        @(posedge clk_in);
        #1 chk({31'h0, sel}, {31'h0, f});
    endtask : pin_step

    // hang guard, the whole run needs under two hundred cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        #1 chk({31'h0, sel}, 32'h0);
        chk({30'h0, hresp, hready}, 32'h1);
        xfer(1'b0, PCSS_CLK_CFG_ADDR, 32'h0, rd);
        chk(rd, PCSS_ZERO_WORD);
        for (int i = 0; i < 8; i++) begin
            cap <= rows[i][3];
            jmp <= rows[i][2];
            xfer(1'b1, PCSS_CLK_CFG_ADDR, {31'h0, rows[i][1]}, rd);
            @(posedge clk_in);
            #1 chk({31'h0, sel}, {31'h0, rows[i][0]});
            chk({24'h0, mhz}, rows[i][0] ? 32'h42 : 32'h21);
            xfer(1'b0, PCSS_STATUS_ADDR, 32'h0, rd);
            chk(rd, {29'h0, rows[i][2], rows[i][3], rows[i][0]});
            xfer(1'b0, PCSS_CLK_CFG_ADDR, 32'h0, rd);
            chk(rd, {31'h0, rows[i][1]});
        end
        pin_step(1'b1, 1'b0, 1'b0, 1'b1);
        pin_step(1'b0, 1'b0, 1'b1, 1'b0);
        xfer(1'b1, 32'h0000_0008, 32'hffff_fffe, rd);
        xfer(1'b1, PCSS_STATUS_ADDR, 32'h0, rd);
        xfer(1'b0, 32'h0000_0008, 32'h0, rd);
        chk(rd, 32'h0);
        xfer(1'b0, PCSS_CLK_CFG_ADDR, 32'h0, rd);
        chk(rd, 32'h1);
        pin_step(1'b1, 1'b0, 1'b0, 1'b1);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        xfer(1'b0, PCSS_CLK_CFG_ADDR, 32'h0, rd);
        chk(rd, PCSS_ZERO_WORD);
        repeat (3) @(posedge clk_in);
        #1 chk({31'h0, sel}, 32'h0);
        stop_test();
    end
endmodule : test_pci_clock_speed_select
